// ### vme_window_defines.svh
// register offsets, field positions, reset values and code points for the window decoder
`ifndef VME_WINDOW_DEFINES_SVH
`define VME_WINDOW_DEFINES_SVH
`define OFF_S3_BASE     12'hf40
`define OFF_S3_BOUND    12'hf44
`define OFF_S3_OFFSET   12'hf48
`define OFF_LOCMON_CONTROL      12'hf64
`define OFF_LM_BASE     12'hf68
`define OFF_RAI_CTL     12'hf70
`define OFF_RAI_BASE    12'hf74
`define FLD_EN          31
`define FLD_PGM_HI      23
`define FLD_PGM_LO      22
`define FLD_SUP_HI      21
`define FLD_SUP_LO      20
`define FLD_LVAS_HI     18
`define FLD_RVAS_HI     17
`define FLD_VAS_LO      16
`define FLD_B64K_LO     16
`define FLD_B4K_LO      12
`define RST_EN          1'b0
`define RST_PGM         2'b11
`define RST_SUP         2'b11
`define RST_LM_VAS      3'h0
`define RST_B64K        16'h0000
`define RST_B4K         20'h00000
`define AM_GRP_A16      3'h5
`define AM_GRP_A24      3'h7
`define AM_GRP_A32      3'h1
`define AM_GRP_USER1    3'h2
`define AM_GRP_USER2    3'h3
`define AM_LOCK_A16     6'h2c
`define AM_LOCK_A24     6'h32
`define AM_LOCK_A32     6'h05
`define AM_LOW_DATA     2'h1
`define AM_LOW_PROG     2'h2
`endif

// ### vme_window_pkg.sv
// types shared by the window decoder
package vme_window_pkg;
  typedef enum logic [2:0] {
    SP_A16   = 3'b000,
    SP_A24   = 3'b001,
    SP_A32   = 3'b010,
    SP_NONE  = 3'b011,
    SP_USER1 = 3'b110,
    SP_USER2 = 3'b111
  } space_e;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DECODE = 2'b01,
    ST_ACTIVE = 2'b10
  } cyc_state_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [5:0]  am;
    logic        write;
  } vme_cycle_s;
endpackage

// ### vme_slave_window_decode.sv
// slave image 3, location monitor and register access image decode
//
// Contract
// - image 3 base bits 31:16, reset zero
// - image 3 bound bits 31:16, reset zero
// - image 3 offset bits 31:16, reset zero
// - location monitor window 4 Kbyte aligned
// - monitor answers matching AM when enabled
// - monitor stores no write, read undefined
// - monitor control enable and space select
// - program and privilege selects reset to 11
// - address bits 4:3 pick monitor status bit
// - own master access gets own DTACK; here only a monitor hit drives own_dtack_out
// - monitor base bits 31:12, reset zero
// - access image reaches internal registers
// - access image takes single and lock AM
// - RMW keeps register locked until done
// - access image enable, space from straps
// - access image base bits 31:12
// - access base reset follows strap space
// - no image answers without bus master enable
`timescale 1ns/1ns
`include "vme_window_defines.svh"
module vme_slave_window_decode
  import vme_window_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // internal register port
  input  wire logic        reg_rd_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_src_vme_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  output logic             reg_ack_out,
  // vme slave pins
  input  wire logic        vme_as_n_in,
  input  wire logic        vme_reset_n_in,
  input  wire logic [31:0] vme_addr_in,
  input  wire logic [5:0]  vme_am_in,
  input  wire logic        vme_write_n_in,
  input  wire logic        vme_rmw_in,
  // system levels and straps
  input  wire logic        bus_master_enable_in,
  input  wire logic        own_master_in,
  input  wire logic [28:21] power_up_option_bits_in,
  input  wire logic        strap_rai_en_in,
  input  wire logic [1:0]  strap_rai_space_in,
  // decode results
  output logic             image3_hit_out,
  output logic      [31:0] pci_addr_out,
  output logic             locmon_hit_out,
  output logic      [3:0]  local_interrupt_status_set_out,
  output logic             rai_hit_out,
  output logic             own_dtack_out,
  output logic             reg_lock_out
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic space_e space_of(input logic [5:0] am);
    space_e s;
    s = SP_NONE;
    case (am)
      `AM_LOCK_A16: s = SP_A16;
      `AM_LOCK_A24: s = SP_A24;
      `AM_LOCK_A32: s = SP_A32;
      default: begin
        case (am[5:3])
          `AM_GRP_A16:   s = SP_A16;
          `AM_GRP_A24:   s = SP_A24;
          `AM_GRP_A32:   s = SP_A32;
          `AM_GRP_USER1: s = SP_USER1;
          `AM_GRP_USER2: s = SP_USER2;
          default:       s = SP_NONE;
        endcase
      end
    endcase
    return s;
  endfunction

  function automatic logic is_lock(input logic [5:0] am);
    return (am == `AM_LOCK_A16) || (am == `AM_LOCK_A24) || (am == `AM_LOCK_A32);
  endfunction

  // single cycle data or program, privilege-checked; block codes fail
  function automatic logic am_ok(input logic [5:0] am, input logic [1:0] program_data_select,
                                 input logic [1:0] sup);
    logic p;
    logic s;
    p = ((am[1:0] == `AM_LOW_DATA) && program_data_select[0]) || ((am[1:0] == `AM_LOW_PROG) && program_data_select[1]);
    s = am[2] ? sup[1] : sup[0];
    return p && s && !is_lock(am);
  endfunction

  // 4 Kbyte window compare on the bits the space carries
  function automatic logic win_hit(input logic [31:0] a, input logic [19:0] base,
                                   input space_e sp);
    logic h;
    case (sp)
      SP_A16:  h = (a[15:12] == base[3:0]);
      SP_A24:  h = (a[23:12] == base[11:0]);
      default: h = (a[31:12] == base);
    endcase
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and resets

  logic [2:0] as_sync_q;
  logic [2:0] vrst_sync_q;
  logic       vrst_q;
  logic       as_q;
  logic       rst;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      as_sync_q   <= 3'h7;
      vrst_sync_q <= 3'h7;
    end else begin
      as_sync_q   <= {as_sync_q[1:0], vme_as_n_in};
      vrst_sync_q <= {vrst_sync_q[1:0], vme_reset_n_in};
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vrst_q <= 1'b0;
    end else if (vrst_sync_q[2:1] == 2'b00) begin
      vrst_q <= 1'b1;
    end else if (vrst_sync_q[2:1] == 2'b11) begin
      vrst_q <= 1'b0;
    end
  end

  assign rst = sys_rst_in | vrst_q;

  always_ff @(posedge clock_in) begin
    if (rst) begin
      as_q <= 1'b0;
    end else if (as_sync_q[2:1] == 2'b00) begin
      as_q <= 1'b1;
    end else if (as_sync_q[2:1] == 2'b11) begin
      as_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] s3_base_q;
  logic [15:0] s3_bound_q;
  logic [15:0] s3_offset_q;
  logic        lm_en_q;
  logic [1:0]  lm_pgm_q;
  logic [1:0]  lm_sup_q;
  logic [2:0]  lm_vas_q;
  logic [19:0] lm_base_q;
  logic        rai_en_q;
  logic [1:0]  rai_pgm_q;
  logic [1:0]  rai_sup_q;
  logic [1:0]  rai_vas_q;
  logic [19:0] rai_base_q;
  logic        accept;
  logic        wr_ok;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        ack_q;
  logic        lock_q;

  // other sources wait while an RMW holds the lock
  assign accept = (reg_rd_in | reg_wr_in) & ~(lock_q & ~reg_src_vme_in);
  assign wr_ok  = accept & reg_wr_in;

  always_ff @(posedge clock_in) begin
    if (rst) begin
      s3_base_q   <= `RST_B64K;
      s3_bound_q  <= `RST_B64K;
      s3_offset_q <= `RST_B64K;
    end else if (wr_ok) begin
      case (reg_addr_in)
        `OFF_S3_BASE:   s3_base_q   <= reg_wdata_in[31:`FLD_B64K_LO];
        `OFF_S3_BOUND:  s3_bound_q  <= reg_wdata_in[31:`FLD_B64K_LO];
        `OFF_S3_OFFSET: s3_offset_q <= reg_wdata_in[31:`FLD_B64K_LO];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      lm_en_q   <= `RST_EN;
      lm_pgm_q  <= `RST_PGM;
      lm_sup_q  <= `RST_SUP;
      lm_vas_q  <= `RST_LM_VAS;
      lm_base_q <= `RST_B4K;
    end else if (wr_ok && reg_addr_in == `OFF_LOCMON_CONTROL) begin
      lm_en_q  <= reg_wdata_in[`FLD_EN];
      lm_pgm_q <= reg_wdata_in[`FLD_PGM_HI:`FLD_PGM_LO];
      lm_sup_q <= reg_wdata_in[`FLD_SUP_HI:`FLD_SUP_LO];
      lm_vas_q <= reg_wdata_in[`FLD_LVAS_HI:`FLD_VAS_LO];
    end else if (wr_ok && reg_addr_in == `OFF_LM_BASE) begin
      lm_base_q <= reg_wdata_in[31:`FLD_B4K_LO];
    end
  end

  // straps are caught on each clocked reset cycle
  always_ff @(posedge clock_in) begin
    if (rst) begin
      rai_en_q   <= strap_rai_en_in;
      rai_vas_q  <= strap_rai_space_in;
      rai_pgm_q  <= `RST_PGM;
      rai_sup_q  <= `RST_SUP;
      rai_base_q <= `RST_B4K;
      case (space_e'({1'b0, strap_rai_space_in}))
        SP_A16:  rai_base_q[3:0]   <= power_up_option_bits_in[28:25];
        SP_A24:  rai_base_q[11:4]  <= power_up_option_bits_in;
        SP_A32:  rai_base_q[19:12] <= power_up_option_bits_in;
        default: ;
      endcase
    end else if (wr_ok && reg_addr_in == `OFF_RAI_CTL) begin
      rai_en_q  <= reg_wdata_in[`FLD_EN];
      rai_pgm_q <= reg_wdata_in[`FLD_PGM_HI:`FLD_PGM_LO];
      rai_sup_q <= reg_wdata_in[`FLD_SUP_HI:`FLD_SUP_LO];
      rai_vas_q <= reg_wdata_in[`FLD_RVAS_HI:`FLD_VAS_LO];
    end else if (wr_ok && reg_addr_in == `OFF_RAI_BASE) begin
      rai_base_q <= reg_wdata_in[31:`FLD_B4K_LO];
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_addr_in)
      `OFF_S3_BASE:   rdata_d[31:16] = s3_base_q;
      `OFF_S3_BOUND:  rdata_d[31:16] = s3_bound_q;
      `OFF_S3_OFFSET: rdata_d[31:16] = s3_offset_q;
      `OFF_LOCMON_CONTROL: begin
        rdata_d[`FLD_EN]                    = lm_en_q;
        rdata_d[`FLD_PGM_HI:`FLD_PGM_LO]    = lm_pgm_q;
        rdata_d[`FLD_SUP_HI:`FLD_SUP_LO]    = lm_sup_q;
        rdata_d[`FLD_LVAS_HI:`FLD_VAS_LO]   = lm_vas_q;
      end
      `OFF_LM_BASE:   rdata_d[31:12] = lm_base_q;
      `OFF_RAI_CTL: begin
        rdata_d[`FLD_EN]                    = rai_en_q;
        rdata_d[`FLD_PGM_HI:`FLD_PGM_LO]    = rai_pgm_q;
        rdata_d[`FLD_SUP_HI:`FLD_SUP_LO]    = rai_sup_q;
        rdata_d[`FLD_RVAS_HI:`FLD_VAS_LO]   = rai_vas_q;
      end
      `OFF_RAI_BASE:  rdata_d[31:12] = rai_base_q;
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= accept;
      if (accept && reg_rd_in) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_ack_out   = ack_q;

  ////////////////////////////////////////////////////////////////////////
  // cycle capture and decode

  cyc_state_e state_q;
  vme_cycle_s cyc_q;
  space_e     sp;
  logic       lm_hit_c;
  logic       rai_hit_c;
  logic       s3_hit_c;
  logic       img3_q;
  logic       lm_q;
  logic       rai_q;
  logic [3:0] lm_set_q;
  logic       dtack_q;
  logic [31:0] pci_q;

  always_ff @(posedge clock_in) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cyc_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (as_q) begin
            cyc_q   <= '{addr: vme_addr_in, am: vme_am_in, write: ~vme_write_n_in};
            state_q <= ST_DECODE;
          end
        end
        ST_DECODE: state_q <= ST_ACTIVE;
        ST_ACTIVE: begin
          if (!as_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign sp = space_of(cyc_q.am);
  assign s3_hit_c = bus_master_enable_in
                  && (cyc_q.addr[31:16] >= s3_base_q)
                  && (cyc_q.addr[31:16] < s3_bound_q);
  // block codes never match here, so masters keep them away
  assign lm_hit_c = bus_master_enable_in && lm_en_q
                  && am_ok(cyc_q.am, lm_pgm_q, lm_sup_q)
                  && (sp != SP_NONE) && (sp == space_e'(lm_vas_q))
                  && win_hit(cyc_q.addr, lm_base_q, sp);
  assign rai_hit_c = bus_master_enable_in && rai_en_q
                   && (sp != SP_NONE) && (sp == space_e'({1'b0, rai_vas_q}))
                   && (am_ok(cyc_q.am, rai_pgm_q, rai_sup_q) || is_lock(cyc_q.am))
                   && win_hit(cyc_q.addr, rai_base_q, sp);

  // hits stand until the strobe releases; monitor keeps no data
  always_ff @(posedge clock_in) begin
    if (rst || state_q == ST_IDLE) begin
      img3_q  <= 1'b0;
      lm_q    <= 1'b0;
      rai_q   <= 1'b0;
      dtack_q <= 1'b0;
    end else if (state_q == ST_DECODE) begin
      img3_q  <= s3_hit_c;
      lm_q    <= lm_hit_c;
      rai_q   <= rai_hit_c;
      dtack_q <= lm_hit_c & own_master_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      lm_set_q <= 4'h0;
    end else if (state_q == ST_DECODE && lm_hit_c) begin
      lm_set_q <= 4'h1 << cyc_q.addr[4:3];
    end else begin
      lm_set_q <= 4'h0;
    end
  end

  // translated address held from the decode edge
  always_ff @(posedge clock_in) begin
    if (rst) begin
      pci_q <= 32'h0000_0000;
    end else if (state_q == ST_DECODE) begin
      pci_q <= cyc_q.addr + {s3_offset_q, 16'h0000};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst || !as_q) begin
      lock_q <= 1'b0;
    end else if (state_q == ST_ACTIVE && rai_q && vme_rmw_in) begin
      lock_q <= 1'b1;
    end
  end

  assign image3_hit_out = img3_q;
  assign pci_addr_out   = pci_q;
  assign locmon_hit_out = lm_q;
  assign local_interrupt_status_set_out = lm_set_q;
  assign rai_hit_out    = rai_q;
  assign own_dtack_out  = dtack_q;
  assign reg_lock_out   = lock_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  image3_claim_a: assert property (
    @(posedge clock_in) disable iff (rst)
    state_q == ST_DECODE |=> image3_hit_out == $past(s3_hit_c))
    else $error("image 3 claim does not follow window compare");

  bme_gate_a: assert property (
    @(posedge clock_in) disable iff (rst)
    $rose(image3_hit_out || locmon_hit_out || rai_hit_out) |-> $past(bus_master_enable_in))
    else $error("image answered without bus master enable");

  lm_window_a: assert property (
    @(posedge clock_in) disable iff (rst)
    locmon_hit_out && sp == SP_A32 |-> cyc_q.addr[31:12] == lm_base_q)
    else $error("monitor hit outside its 4 Kbyte window");

  lm_status_a: assert property (
    @(posedge clock_in) disable iff (rst)
    $rose(locmon_hit_out) |-> $onehot(local_interrupt_status_set_out)
      && local_interrupt_status_set_out[cyc_q.addr[4:3]] ##1 local_interrupt_status_set_out == 4'h0)
    else $error("monitor status bit not chosen by address 4:3");

  lm_no_block_a: assert property (
    @(posedge clock_in) disable iff (rst)
    locmon_hit_out |-> cyc_q.am[1:0] != 2'b11 && cyc_q.am[1:0] != 2'b00)
    else $error("monitor hit on a block transfer code");

  own_dtack_a: assert property (
    @(posedge clock_in) disable iff (rst)
    $rose(locmon_hit_out) && $past(own_master_in) |-> own_dtack_out ##1 own_dtack_out || !as_q)
    else $error("own master monitor access not ended locally");

  rai_am_a: assert property (
    @(posedge clock_in) disable iff (rst)
    rai_hit_out |-> is_lock(cyc_q.am) || am_ok(cyc_q.am, rai_pgm_q, rai_sup_q))
    else $error("access image took a refused modifier code");

  lock_hold_a: assert property (
    @(posedge clock_in) disable iff (rst)
    reg_lock_out && !reg_src_vme_in && (reg_rd_in || reg_wr_in) && as_q |=> !reg_ack_out)
    else $error("locked register reached by another source");

  zero_reset_a: assert property (
    @(posedge clock_in)
    $past(rst) |-> s3_base_q == 16'h0 && s3_bound_q == 16'h0 && s3_offset_q == 16'h0
      && lm_base_q == 20'h0 && lm_pgm_q == 2'b11 && rai_sup_q == 2'b11)
    else $error("register reset value wrong");

endmodule

// ### vme_master_model.sv
// backplane master model driving cycles into the window decoder
`timescale 1ns/1ns
module vme_master_model (
  // clock
  input  wire logic        clock_in,
  // backplane lines
  output logic             as_n_out,
  output logic      [31:0] addr_out,
  output logic      [5:0]  am_out,
  output logic             write_n_out,
  output logic             rmw_out
);
  initial begin
    as_n_out    = 1'b1;
    addr_out    = 32'h0;
    am_out      = 6'h0;
    write_n_out = 1'b1;
    rmw_out     = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // block codes only when a refusal is wanted
  task automatic start(input logic [31:0] a, input logic [5:0] m,
                       input logic wn, input logic r);
    @(posedge clock_in);
    #2;
    addr_out    = a;
    am_out      = m;
    write_n_out = wn;
    rmw_out     = r;
    as_n_out    = 1'b0;
  endtask
  // released address, modifier and write lines show the inverse of their last value
  task automatic stop();
    @(posedge clock_in);
    #2;
    as_n_out    = 1'b1;
    rmw_out     = 1'b0;
    addr_out    = ~addr_out;
    am_out      = ~am_out;
    write_n_out = ~write_n_out;
    repeat (6) @(posedge clock_in);
    #2;
  endtask
endmodule

// ### tb_top.sv
// self-checking bench for the vme window decoder
`timescale 1ns/1ns
module tb_top;
  logic        clk, rst, rd, wr, src, bme, own, ren, vrst_n;
  logic        ack, h3, hl, hr, dt, lk, as_n, wn, rmw;
  logic [1:0]  rsp;
  logic [7:0]  opt;
  logic [11:0] ra;
  logic [31:0] wd, rdat, pa, va;
  logic [5:0]  am;
  logic [3:0]  st, seen;
  int          n_mismatch, samples_checked, n_ack, i;
  logic [11:0] oa [7] = '{12'hf40, 12'hf44, 12'hf48, 12'hf64, 12'hf68, 12'hf70, 12'hf74};
  logic [31:0] om [7] = '{32'hffff_0000, 32'hffff_0000, 32'hffff_0000, 32'h80f7_0000,
                          32'hffff_f000, 32'h80f3_0000, 32'hffff_f000};
  logic [2:0]  sv [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  logic [5:0]  sa [5] = '{6'h2d, 6'h39, 6'h0d, 6'h11, 6'h19};
  logic [31:0] bx [3] = '{32'h0000_5000, 32'h005a_0000, 32'h5a00_0000};
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  vme_slave_window_decode dut_u (
    .clock_in(clk), .sys_rst_in(rst), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_src_vme_in(src), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .reg_ack_out(ack), .vme_as_n_in(as_n),
    .vme_reset_n_in(vrst_n), .vme_addr_in(va), .vme_am_in(am),
    .vme_write_n_in(wn), .vme_rmw_in(rmw), .bus_master_enable_in(bme),
    .own_master_in(own), .power_up_option_bits_in(opt), .strap_rai_en_in(ren),
    .strap_rai_space_in(rsp), .image3_hit_out(h3), .pci_addr_out(pa),
    .locmon_hit_out(hl), .local_interrupt_status_set_out(st), .rai_hit_out(hr),
    .own_dtack_out(dt), .reg_lock_out(lk)
  );
  vme_master_model m_u (
    .clock_in(clk), .as_n_out(as_n), .addr_out(va), .am_out(am),
    .write_n_out(wn), .rmw_out(rmw)
  );
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    #2;
    rd = ~w;
    wr = w;
    ra = a;
    wd = d;
    for (k = 0; k < 40 && ack !== 1'b1; k++) begin
      @(posedge clk);
      #2;
    end
    rd = 1'b0;
    wr = 1'b0;
    chk("ack", 32'h1, 32'(ack));
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  task automatic vc(input logic [31:0] a, input logic [5:0] m, input logic n,
                    input logic [2:0] eh, input logic [3:0] es, input logic [31:0] ep);
    seen = 4'h0;
    m_u.start(a, m, n, 1'b0);
    repeat (8) begin
      @(posedge clk);
      #2;
      seen = seen | st;
    end
    chk("hits", 32'(eh), 32'({h3, hl, hr}));
    chk("status set", 32'(es), 32'(seen));
    chk("dtack", 32'(eh[1] & own), 32'(dt));
    if (eh[2]) chk("pci address", ep, pa);
    m_u.stop();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    n_mismatch++;
    conclude();
  end
  initial begin
    {rst, rd, wr, src, bme, own, ren, vrst_n} = 8'h8b;
    {rsp, opt, ra, wd, seen} = {2'h1, 8'ha5, 12'h0, 32'h0, 4'h0};
    {n_mismatch, samples_checked, n_ack} = 0;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    rchk(12'hf40, 32'h0);
    rchk(12'hf44, 32'h0);
    rchk(12'hf48, 32'h0);
    rchk(12'hf64, 32'h00f0_0000);
    rchk(12'hf68, 32'h0);
    rchk(12'hf70, 32'h80f1_0000);
    rchk(12'hf74, 32'h00a5_0000);
    rchk(12'h000, 32'h0);
    for (i = 0; i < 7; i++) begin
      acc(1'b1, oa[i], 32'hffff_ffff);
      rchk(oa[i], om[i]);
    end
    acc(1'b1, 12'hf40, 32'h1234_0000);
    acc(1'b1, 12'hf44, 32'h1240_0000);
    acc(1'b1, 12'hf48, 32'h0010_0000);
    acc(1'b1, 12'hf64, 32'h0);
    acc(1'b1, 12'hf70, 32'h0);
    vc(32'h1234_0000, 6'h0d, 1'b1, 3'h4, 4'h0, 32'h1244_0000);
    vc(32'h123f_fffc, 6'h0d, 1'b1, 3'h4, 4'h0, 32'h124f_fffc);
    vc(32'h1240_0000, 6'h0d, 1'b1, 3'h0, 4'h0, 32'h0);
    vc(32'h1233_fffc, 6'h0d, 1'b1, 3'h0, 4'h0, 32'h0);
    bme = 1'b0;
    vc(32'h1234_0000, 6'h0d, 1'b1, 3'h0, 4'h0, 32'h0);
    bme = 1'b1;
    acc(1'b1, 12'hf68, 32'h0055_6000);
    acc(1'b1, 12'hf64, 32'h80f1_0000);
    own = 1'b1;
    for (i = 0; i < 4; i++) begin
      vc(32'h0055_6000 | 32'(i << 3), 6'h39, 1'b1, 3'h2, 4'h1 << i, 32'h0);
    end
    own = 1'b0;
    vc(32'h0055_6ffc, 6'h39, 1'b0, 3'h2, 4'h8, 32'h0);
    vc(32'h0055_7000, 6'h39, 1'b1, 3'h0, 4'h0, 32'h0);
    vc(32'h0055_5ff8, 6'h39, 1'b1, 3'h0, 4'h0, 32'h0);
    vc(32'h0055_6000, 6'h3b, 1'b1, 3'h0, 4'h0, 32'h0);
    rchk(12'hf68, 32'h0055_6000);
    for (i = 0; i < 5; i++) begin
      acc(1'b1, 12'hf64, {8'h80, 5'h1e, sv[i], 16'h0});
      vc(32'h0055_6010, sa[i], 1'b1, 3'h2, 4'h4, 32'h0);
    end
    vc(32'h0055_6010, 6'h39, 1'b1, 3'h0, 4'h0, 32'h0);
    acc(1'b1, 12'hf64, 32'h8071_0000);
    vc(32'h0055_6000, 6'h3a, 1'b1, 3'h0, 4'h0, 32'h0);
    acc(1'b1, 12'hf64, 32'h80e1_0000);
    vc(32'h0055_6000, 6'h39, 1'b1, 3'h0, 4'h0, 32'h0);
    vc(32'h0055_6000, 6'h3d, 1'b1, 3'h2, 4'h1, 32'h0);
    acc(1'b1, 12'hf64, 32'h00f1_0000);
    vc(32'h0055_6000, 6'h39, 1'b1, 3'h0, 4'h0, 32'h0);
    acc(1'b1, 12'hf74, 32'h00a5_0000);
    acc(1'b1, 12'hf70, 32'h80f1_0000);
    vc(32'h00a5_0100, 6'h39, 1'b1, 3'h1, 4'h0, 32'h0);
    vc(32'h00a5_0100, 6'h3b, 1'b1, 3'h0, 4'h0, 32'h0);
    vc(32'h00a5_0100, 6'h32, 1'b1, 3'h1, 4'h0, 32'h0);
    m_u.start(32'h00a5_0100, 6'h32, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    #2;
    chk("lock", 32'h1, 32'(lk));
    src = 1'b1;
    rchk(12'hf40, 32'h1234_0000);
    src = 1'b0;
    n_ack = 0;
    fork
      acc(1'b1, 12'hf40, 32'h0777_0000);
      begin
        repeat (6) begin
          @(posedge clk);
          #2;
          if (ack === 1'b1) n_ack++;
        end
        chk("refused ack", 32'h0, 32'(n_ack));
        m_u.stop();
      end
    join
    chk("lock", 32'h0, 32'(lk));
    rchk(12'hf40, 32'h0777_0000);
    vrst_n = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    vrst_n = 1'b1;
    repeat (4) @(posedge clk);
    rchk(12'hf40, 32'h0);
    rchk(12'hf64, 32'h00f0_0000);
    for (i = 0; i < 3; i++) begin
      rsp = 2'(i);
      ren = i[0];
      opt = 8'h5a;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      #2;
      rst = 1'b0;
      rchk(12'hf70, {ren, 7'h0, 6'h3c, rsp, 16'h0});
      rchk(12'hf74, bx[i]);
    end
    conclude();
  end
endmodule
